/* File: shared/lgis_pkg.sv */
// Package with register map, field layout and carrier types for the gate input select stage.
package lgis_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int NUM_GATES = 4;
  localparam int NUM_SRCS = 4;
  localparam int BITS_PER_GATE = 2 * NUM_SRCS;
  localparam logic [ADDR_W-1:0] ADDR_SEL_LO = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_SEL_HI = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_POL = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_GATE_OUT = 4'h3;
  localparam logic [DATA_W-1:0] SEL_RESET = 16'h0000;
  localparam logic [NUM_GATES-1:0] POL_RESET = 4'h0;
  // Within each gate's byte: odd bit is the true enable, even bit the inverted one.
  localparam int TRUE_OFS = 1;
  localparam int INV_OFS = 0;
  localparam int POL_LSB = 0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lgis_req_s;

  typedef struct packed {
    logic [NUM_GATES-1:0][BITS_PER_GATE-1:0] en;
    logic [NUM_GATES-1:0] pol;
  } lgis_cfg_s;
endpackage

/* File: src/lgis_gate.sv */
// One gate: OR of enabled true and inverted data sources, then polarity.
`timescale 1ns/1ps
module lgis_gate (
  input wire logic [lgis_pkg::NUM_SRCS-1:0] i_src,
  input wire logic [lgis_pkg::BITS_PER_GATE-1:0] i_en,
  input wire logic i_pol,
  output logic o_gate
);
  logic [lgis_pkg::BITS_PER_GATE-1:0] cand;
  logic ored;

  genvar s;
  generate
    for (s = 0; s < lgis_pkg::NUM_SRCS; s++) begin : g_src
      // Both polarities of each source are offered to the gate.
      assign cand[2*s+lgis_pkg::TRUE_OFS] = i_src[s];
      assign cand[2*s+lgis_pkg::INV_OFS] = ~i_src[s];
    end
  endgenerate

  // Disabled candidates are masked off; an empty selection gives zero.
  assign ored = |(cand & i_en);
  assign o_gate = ored ^ i_pol;
endmodule // lgis_gate

/* File: src/lgis_top.sv */
// Gate input select stage: select registers, polarity register and four gates.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
//Function
// - Gate 1 true inputs of sources 4..1 enabled by low register bits 7,5,3,1.
// - Gate 1 inverted inputs of sources 4..1 enabled by low bits 6,4,2,0.
// - Gate 2 true inputs enabled by low register bits 15,13,11,9.
// - Gate 2 inverted inputs enabled by low register bits 14,12,10,8.
// - Gate 3 true inputs enabled by high register bits 7,5,3,1.
// - Gate 3 inverted inputs enabled by high register bits 6,4,2,0.
// - Gate 4 true inputs enabled by high register bits 15,13,11,9.
// - Gate 4 inverted inputs enabled by high register bits 14,12,10,8.
// - A cleared enable bit keeps its signal out of the gate.
// - All enable bits are read/write and reset to zero.
// - Each source offers true and inverted forms, eight candidates per gate.
// - Each gate ORs all enabled signals.
// - A gate with nothing enabled gives its polarity value.
// - A set polarity bit inverts the gate's ORed result.
module lgis_top (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [lgis_pkg::ADDR_W-1:0] i_addr,
  input wire logic [lgis_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [lgis_pkg::DATA_W-1:0] o_rdata,
  input wire logic [lgis_pkg::NUM_SRCS-1:0] i_src,
  output logic [lgis_pkg::NUM_GATES-1:0] o_gate
);
  lgis_pkg::lgis_req_s req;
  lgis_pkg::lgis_cfg_s cfg;
  logic [lgis_pkg::DATA_W-1:0] sel_lo_ff;
  logic [lgis_pkg::DATA_W-1:0] sel_hi_ff;
  logic [lgis_pkg::NUM_GATES-1:0] pol_ff;
  logic [lgis_pkg::DATA_W-1:0] rdata_ff;
  logic [lgis_pkg::DATA_W-1:0] nxt_rdata;
  logic [lgis_pkg::NUM_GATES-1:0] gate_now;
  logic [lgis_pkg::DATA_W-1:0] last_wdata_ff;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  function automatic logic hit(input lgis_pkg::lgis_req_s r, input logic [3:0] a);
    hit = (r.addr == a);
  endfunction

  // Reference gate built term by term, so the checks do not reuse the mask-and-reduce path.
  function automatic logic gate_ref(
    input logic [lgis_pkg::NUM_SRCS-1:0] s,
    input logic [lgis_pkg::BITS_PER_GATE-1:0] e,
    input logic p
  );
    logic acc;
    acc = 1'b0;
    for (int k = 0; k < lgis_pkg::NUM_SRCS; k++) begin
      acc = acc | (e[2*k+lgis_pkg::TRUE_OFS] & s[k]) | (e[2*k+lgis_pkg::INV_OFS] & ~s[k]);
    end
    gate_ref = acc ^ p;
  endfunction

  // Select registers; outputs of the gates follow from the next cycle.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sel_lo_ff <= lgis_pkg::SEL_RESET;
      sel_hi_ff <= lgis_pkg::SEL_RESET;
    end else if (req.wr) begin
      if (hit(req, lgis_pkg::ADDR_SEL_LO)) begin
        sel_lo_ff <= req.wdata;
      end
      if (hit(req, lgis_pkg::ADDR_SEL_HI)) begin
        sel_hi_ff <= req.wdata;
      end
    end
  end

  // Gate polarity controls.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pol_ff <= lgis_pkg::POL_RESET;
    end else if (req.wr && hit(req, lgis_pkg::ADDR_POL)) begin
      pol_ff <= req.wdata[lgis_pkg::POL_LSB +: lgis_pkg::NUM_GATES];
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    nxt_rdata = 16'h0000;
    case (req.addr)
      lgis_pkg::ADDR_SEL_LO: nxt_rdata = sel_lo_ff;
      lgis_pkg::ADDR_SEL_HI: nxt_rdata = sel_hi_ff;
      lgis_pkg::ADDR_POL: nxt_rdata = {12'h000, pol_ff};
      lgis_pkg::ADDR_GATE_OUT: nxt_rdata = {12'h000, o_gate};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rdata_ff <= 16'h0000;
    end else if (req.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 16'h0000;
    end
  end
  assign o_rdata = rdata_ff;

  // Last written word, kept only so the checks can see when a write reaches the gates.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      last_wdata_ff <= lgis_pkg::SEL_RESET;
    end else if (req.wr) begin
      last_wdata_ff <= req.wdata;
    end
  end

  // Low register: gate 1 in bits 7..0, gate 2 in 15..8; high likewise for gates 3, 4.
  always_comb begin
    cfg.en[0] = sel_lo_ff[7:0];
    cfg.en[1] = sel_lo_ff[15:8];
    cfg.en[2] = sel_hi_ff[7:0];
    cfg.en[3] = sel_hi_ff[15:8];
    cfg.pol = pol_ff;
  end

  genvar g;
  generate
    for (g = 0; g < lgis_pkg::NUM_GATES; g++) begin : g_gate
      lgis_gate u_gate (
        .i_src(i_src),
        .i_en(cfg.en[g]),
        .i_pol(cfg.pol[g]),
        .o_gate(gate_now[g])
      );
    end
  endgenerate

  // Gates are combinational from the registered enables and live sources.
  assign o_gate = gate_now;

  sequence s_wr_lo;
    i_wr && i_addr == lgis_pkg::ADDR_SEL_LO;
  endsequence

  sequence s_wr_hi;
    i_wr && i_addr == lgis_pkg::ADDR_SEL_HI;
  endsequence

  sequence s_wr_pol;
    i_wr && i_addr == lgis_pkg::ADDR_POL;
  endsequence

  sequence s_rd_lo;
    i_rd && !i_wr && i_addr == lgis_pkg::ADDR_SEL_LO;
  endsequence

  sequence s_rd_hi;
    i_rd && !i_wr && i_addr == lgis_pkg::ADDR_SEL_HI;
  endsequence

  sequence s_rd_pol;
    i_rd && !i_wr && i_addr == lgis_pkg::ADDR_POL;
  endsequence

  property p_reset_clears;
    @(posedge i_mclk) i_reset |=> (sel_lo_ff == lgis_pkg::SEL_RESET &&
      sel_hi_ff == lgis_pkg::SEL_RESET && pol_ff == lgis_pkg::POL_RESET);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("select not cleared");

  property p_write_lo;
    @(posedge i_mclk) disable iff (i_reset)
      s_wr_lo |=> (sel_lo_ff == $past(i_wdata));
  endproperty
  a_write_lo: assert property (p_write_lo) else $error("low select write lost");

  property p_write_hi;
    @(posedge i_mclk) disable iff (i_reset)
      s_wr_hi |=> (sel_hi_ff == $past(i_wdata));
  endproperty
  a_write_hi: assert property (p_write_hi) else $error("high select write lost");

  property p_readback;
    @(posedge i_mclk) disable iff (i_reset)
      s_rd_lo |=> (o_rdata == $past(sel_lo_ff));
  endproperty
  a_readback: assert property (p_readback) else $error("low select readback wrong");

  property p_empty_gate1;
    @(posedge i_mclk) disable iff (i_reset) (sel_lo_ff[7:0] == 8'h00) |-> (o_gate[0] == pol_ff[0]);
  endproperty
  a_empty_gate1: assert property (p_empty_gate1) else $error("empty gate 1 wrong");

  property p_g1_true;
    @(posedge i_mclk) disable iff (i_reset)
      (sel_lo_ff[7:0] == 8'h80 && !pol_ff[0]) |-> (o_gate[0] == i_src[3]);
  endproperty
  a_g1_true: assert property (p_g1_true) else $error("gate 1 source 4 true wrong");

  property p_g2_inv;
    @(posedge i_mclk) disable iff (i_reset)
      (sel_lo_ff[15:8] == 8'h01 && !pol_ff[1]) |-> (o_gate[1] == !i_src[0]);
  endproperty
  a_g2_inv: assert property (p_g2_inv) else $error("gate 2 source 1 inverted wrong");

  property p_g3_or_pol;
    @(posedge i_mclk) disable iff (i_reset)
      (sel_hi_ff[7:0] == 8'h22 && pol_ff[2]) |-> (o_gate[2] == !(i_src[0] | i_src[2]));
  endproperty
  a_g3_or_pol: assert property (p_g3_or_pol) else $error("gate 3 or/polarity wrong");

  property p_g4_both;
    @(posedge i_mclk) disable iff (i_reset)
      (sel_hi_ff[15:8] == 8'h0c && !pol_ff[3]) |-> (o_gate[3] == 1'b1);
  endproperty
  a_g4_both: assert property (p_g4_both) else $error("gate 4 true or inverted wrong");

  property p_reset_outputs;
    @(posedge i_mclk)
      i_reset |=> (o_rdata == 16'h0000 && o_gate == 4'h0);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared");

  property p_write_pol;
    @(posedge i_mclk) disable iff (i_reset)
      s_wr_pol |=> (pol_ff == $past(i_wdata[lgis_pkg::POL_LSB +: lgis_pkg::NUM_GATES]));
  endproperty
  a_write_pol: assert property (p_write_pol) else $error("polarity write lost");

  property p_readback_hi;
    @(posedge i_mclk) disable iff (i_reset)
      s_rd_hi |=> (o_rdata == $past(sel_hi_ff));
  endproperty
  a_readback_hi: assert property (p_readback_hi) else $error("high select readback wrong");

  property p_readback_pol;
    @(posedge i_mclk) disable iff (i_reset)
      s_rd_pol |=> (o_rdata == {12'h000, $past(pol_ff)});
  endproperty
  a_readback_pol: assert property (p_readback_pol) else $error("polarity readback wrong");

  property p_rdata_idle;
    @(posedge i_mclk) disable iff (i_reset)
      !i_rd |=> (o_rdata == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_hold_lo;
    @(posedge i_mclk) disable iff (i_reset)
      !(i_wr && i_addr == lgis_pkg::ADDR_SEL_LO) |=> $stable(sel_lo_ff);
  endproperty
  a_hold_lo: assert property (p_hold_lo) else $error("low select changed unwritten");

  property p_hold_hi;
    @(posedge i_mclk) disable iff (i_reset)
      !(i_wr && i_addr == lgis_pkg::ADDR_SEL_HI) |=> $stable(sel_hi_ff);
  endproperty
  a_hold_hi: assert property (p_hold_hi) else $error("high select changed unwritten");

  property p_gate1_ref;
    @(posedge i_mclk) disable iff (i_reset)
      o_gate[0] == gate_ref(i_src, sel_lo_ff[7:0], pol_ff[0]);
  endproperty
  a_gate1_ref: assert property (p_gate1_ref) else $error("gate 1 differs from reference");

  property p_gate2_ref;
    @(posedge i_mclk) disable iff (i_reset)
      o_gate[1] == gate_ref(i_src, sel_lo_ff[15:8], pol_ff[1]);
  endproperty
  a_gate2_ref: assert property (p_gate2_ref) else $error("gate 2 differs from reference");

  property p_gate3_ref;
    @(posedge i_mclk) disable iff (i_reset)
      o_gate[2] == gate_ref(i_src, sel_hi_ff[7:0], pol_ff[2]);
  endproperty
  a_gate3_ref: assert property (p_gate3_ref) else $error("gate 3 differs from reference");

  property p_gate4_ref;
    @(posedge i_mclk) disable iff (i_reset)
      o_gate[3] == gate_ref(i_src, sel_hi_ff[15:8], pol_ff[3]);
  endproperty
  a_gate4_ref: assert property (p_gate4_ref) else $error("gate 4 differs from reference");

  property p_g1_masked;
    @(posedge i_mclk) disable iff (i_reset)
      (sel_lo_ff[1:0] == 2'b00 && $changed(i_src[0]) && $stable(i_src[3:1]) &&
        $stable(sel_lo_ff) && $stable(pol_ff)) |-> $stable(o_gate[0]);
  endproperty
  a_g1_masked: assert property (p_g1_masked) else $error("disabled source 1 reached gate 1");

  property p_empty_gate4;
    @(posedge i_mclk) disable iff (i_reset)
      (sel_hi_ff[15:8] == 8'h00) |-> (o_gate[3] == pol_ff[3]);
  endproperty
  a_empty_gate4: assert property (p_empty_gate4) else $error("empty gate 4 wrong");

  property p_g1_inv_src3;
    @(posedge i_mclk) disable iff (i_reset)
      (sel_lo_ff[7:0] == 8'h10 && !pol_ff[0]) |-> (o_gate[0] == !i_src[2]);
  endproperty
  a_g1_inv_src3: assert property (p_g1_inv_src3) else $error("gate 1 source 3 inverted wrong");

  property p_g3_inv_src2;
    @(posedge i_mclk) disable iff (i_reset)
      (sel_hi_ff[7:0] == 8'h04 && !pol_ff[2]) |-> (o_gate[2] == !i_src[1]);
  endproperty
  a_g3_inv_src2: assert property (p_g3_inv_src2) else $error("gate 3 source 2 inverted wrong");

  property p_g4_inv_src4;
    @(posedge i_mclk) disable iff (i_reset)
      (sel_hi_ff[15:8] == 8'h40 && !pol_ff[3]) |-> (o_gate[3] == !i_src[3]);
  endproperty
  a_g4_inv_src4: assert property (p_g4_inv_src4) else $error("gate 4 source 4 inverted wrong");

  property p_all_candidates;
    @(posedge i_mclk) disable iff (i_reset)
      (sel_lo_ff[7:0] == 8'hff) |-> (o_gate[0] == !pol_ff[0]);
  endproperty
  a_all_candidates: assert property (p_all_candidates) else $error("gate 1 full select wrong");

  property p_effect_lo;
    @(posedge i_mclk) disable iff (i_reset)
      s_wr_lo |=> (o_gate[0] == gate_ref(i_src, last_wdata_ff[7:0], pol_ff[0])) &&
        (o_gate[1] == gate_ref(i_src, last_wdata_ff[15:8], pol_ff[1]));
  endproperty
  a_effect_lo: assert property (p_effect_lo) else $error("low select write not applied");
endmodule // lgis_top

/* File: testbench/tb.sv */
// Self-checking testbench for the gate input select stage.
`timescale 1ns/1ps
module tb;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic [lgis_pkg::ADDR_W-1:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] i_src = 4'h0;
  logic [15:0] o_rdata;
  logic [3:0] o_gate;
  logic [15:0] sel_lo = 16'h0000;
  logic [15:0] sel_hi = 16'h0000;
  logic [3:0] pol = 4'h0;
  logic [35:0] cases [5] = '{36'h00000000f, 36'h5555aaaa5, 36'ha0a00a0ac, 36'hffffffff3,
    36'h01800c224};
  int failures = 0;
  int num_checks = 0;
  always #12.5 i_mclk = ~i_mclk;
  lgis_top u_lgis_top (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_src(i_src), .o_gate(o_gate));
  // Reference gate outputs worked out from the mirrored registers.
  function automatic logic [3:0] gate_model(input logic [3:0] s);
    logic [31:0] en;
    logic [3:0] g;
    en = {sel_hi, sel_lo};
    g = 4'h0;
    for (int k = 0; k < 32; k++) begin
      if (en[k]) g[k/8] = g[k/8] | ((k % 2 == 1) ? s[(k%8)/2] : ~s[(k%8)/2]);
    end
    return g ^ pol;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    if (a == lgis_pkg::ADDR_SEL_LO) sel_lo = d;
    if (a == lgis_pkg::ADDR_SEL_HI) sel_hi = d;
    if (a == lgis_pkg::ADDR_POL) pol = d[3:0];
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    check(o_rdata, exp);
  endtask
  // Every source combination is applied so each source is seen both high and low.
  task automatic sweep();
    for (int s = 0; s < 16; s++) begin
      @(posedge i_mclk);
      i_src <= s[3:0];
      #1;
      check({12'h000, o_gate}, {12'h000, gate_model(s[3:0])});
    end
  endtask
  initial begin
    repeat (5000) @(posedge i_mclk);
    failures++;
    summarize();
  end
  initial begin
    logic [3:0] a;
    repeat (4) @(posedge i_mclk);
    i_reset <= 1'b0;
    rd(lgis_pkg::ADDR_SEL_LO, 16'h0000);
    rd(lgis_pkg::ADDR_SEL_HI, 16'h0000);
    sweep();
    $display("reset test done");
    for (int r = 0; r < 2; r++) begin
      a = (r == 1) ? lgis_pkg::ADDR_SEL_HI : lgis_pkg::ADDR_SEL_LO;
      for (int b = 0; b < 16; b++) begin
        wr(a, 16'h0001 << b);
        check({12'h000, o_gate}, {12'h000, gate_model(i_src)});
        rd(a, 16'h0001 << b);
        sweep();
      end
      wr(a, 16'h0000);
    end
    $display("single enable test done");
    for (int t = 0; t < 5; t++) begin
      wr(lgis_pkg::ADDR_SEL_LO, cases[t][35:20]);
      wr(lgis_pkg::ADDR_SEL_HI, cases[t][19:4]);
      wr(lgis_pkg::ADDR_POL, {12'h000, cases[t][3:0]});
      sweep();
      rd(lgis_pkg::ADDR_GATE_OUT, {12'h000, gate_model(i_src)});
      rd(lgis_pkg::ADDR_SEL_HI, cases[t][19:4]);
      rd(lgis_pkg::ADDR_POL, {12'h000, cases[t][3:0]});
      rd(4'h7, 16'h0000);
    end
    $display("combination test done");
    // A second reset in mid-run must clear everything written above.
    @(posedge i_mclk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    sel_lo = 16'h0000;
    sel_hi = 16'h0000;
    pol = 4'h0;
    rd(lgis_pkg::ADDR_SEL_LO, 16'h0000);
    rd(lgis_pkg::ADDR_SEL_HI, 16'h0000);
    rd(lgis_pkg::ADDR_POL, 16'h0000);
    check({12'h000, o_gate}, {12'h000, gate_model(i_src)});
    $display("mid-run reset test done");
    summarize();
  end
endmodule // tb
